// *** include/strap_decoder_pkg.sv ***
/*
  Constants and types for the drive option strap decoder.
  Assumes strap inputs read 1 when the jumper is shorted and 0 when open.
*/
package strap_decoder_pkg;

  // Capture sequencing: LOAD samples straps, HOLD keeps them
  typedef enum logic [0:0] {
    ST_LOAD = 1'b0,
    ST_HOLD = 1'b1
  } cap_state_t;

  localparam int unsigned ADDR_W          = 3;
  localparam int unsigned MODE_BYTE_W     = 8;
  // SCSI-1 select bit inside byte 8 of mode page 09
  localparam int unsigned SCSI1_MODE_BIT  = 4;

  // Values held from reset until the first capture
  localparam logic              RST_FLAG    = 1'b0;
  localparam logic [ADDR_W-1:0] RST_ADDR    = 3'h0;

endpackage : strap_decoder_pkg

// *** logic/drive_option_strap_decoder.sv ***
/*
  Drive option strap decoder: samples the option and address jumpers at power-on
  reset and SCSI bus reset, holds the decoded configuration and routes the spindle
  sync line to bus pin 29.
  Assumes all inputs are synchronous to ref_clk, a shorted strap reads as 1, and
  the firmware holds mode page settings as levels and supplies Start/Stop Unit events as pulses.
*/
// What this block does
// - Auto spin-up strap shorted starts spindle at power-on; open waits for Start Unit
// - Bus parity checked on received data only while parity strap is shorted
// - SDTR strap shorted makes drive send SDTR after power-on and reset
// - Unit attention reported when strap open, suppressed when shorted
// - Fast seek enabled only while its strap is shorted
// - Protocol strap shorted forces SCSI-1; open follows mode page 09 byte 8 bit 4
// - Write protect strap forces protection; open follows mode page header setting
// - Unit select straps 1,2,4 weighted form the three-bit bus address
// - With sync spindle mode on, routing straps drive or ground pin 29; equal settings illegal
// - Master spindle sync driven out, slave spindle sync accepted as input
module drive_option_strap_decoder (
  input  wire logic                                      ref_clk,
  input  wire logic                                      reset,
  input  wire logic                                      bus_reset,
  input  wire logic                                      strap_auto_spin,
  input  wire logic                                      strap_parity,
  input  wire logic                                      strap_sdtr,
  input  wire logic                                      strap_unit_attn,
  input  wire logic                                      strap_fast_seek,
  input  wire logic                                      strap_scsi1,
  input  wire logic                                      strap_write_prot,
  input  wire logic [strap_decoder_pkg::ADDR_W-1:0]      strap_unit_sel,
  input  wire logic                                      strap_sync_route,
  input  wire logic                                      strap_pin29_gnd,
  input  wire logic                                      start_unit_cmd,
  input  wire logic                                      stop_unit_cmd,
  input  wire logic                                      rx_parity_bad,
  input  wire logic                                      unit_attn_pending,
  input  wire logic [strap_decoder_pkg::MODE_BYTE_W-1:0] mode_page09_byte8,
  input  wire logic                                      mode_hdr_write_prot,
  input  wire logic                                      sync_spindle_mode,
  input  wire logic                                      spindle_master,
  input  wire logic                                      spindle_index,
  input  wire logic                                      slave_sync_in,
  input  wire logic                                      pin29_in,
  output logic                                           config_valid,
  output logic                                           spindle_run,
  output logic                                           parity_check_en,
  output logic                                           parity_error,
  output logic                                           sdtr_request,
  output logic                                           unit_attn_report,
  output logic                                           fast_seek_en,
  output logic                                           scsi1_mode,
  output logic                                           write_protect,
  output logic [strap_decoder_pkg::ADDR_W-1:0]           scsi_id,
  output logic                                           route_illegal,
  output logic                                           pin29_out,
  output logic                                           pin29_oe,
  output logic                                           master_sync_out,
  output logic                                           slave_sync_seen
);

  strap_decoder_pkg::cap_state_t      state_reg, state_next;
  logic                               auto_spin_reg, auto_spin_next;
  logic                               run_reg, run_next;
  logic                               par_en_reg, par_en_next;
  logic                               par_err_reg, par_err_next;
  logic                               sdtr_en_reg, sdtr_en_next;
  logic                               sdtr_req_reg, sdtr_req_next;
  logic                               ua_inhibit_reg, ua_inhibit_next;
  logic                               ua_rep_reg, ua_rep_next;
  logic                               fseek_reg, fseek_next;
  logic                               s1_strap_reg, s1_strap_next;
  logic                               s1_mode_reg, s1_mode_next;
  logic                               wp_strap_reg, wp_strap_next;
  logic                               wp_reg, wp_next;
  logic [strap_decoder_pkg::ADDR_W-1:0] id_reg, id_next;
  logic                               route_sync_reg, route_sync_next;
  logic                               route_gnd_reg, route_gnd_next;
  logic                               msync_reg, msync_next;
  logic                               ssync_reg, ssync_next;
  logic                               capture;

  // Straps are sampled in the cycle after reset release and while bus reset is held
  assign capture = (state_reg == strap_decoder_pkg::ST_LOAD) || bus_reset;

  always_comb begin
    state_next      = bus_reset ? strap_decoder_pkg::ST_LOAD : strap_decoder_pkg::ST_HOLD;
    auto_spin_next  = auto_spin_reg;
    par_en_next     = par_en_reg;
    sdtr_en_next    = sdtr_en_reg;
    ua_inhibit_next = ua_inhibit_reg;
    fseek_next      = fseek_reg;
    s1_strap_next   = s1_strap_reg;
    wp_strap_next   = wp_strap_reg;
    id_next         = id_reg;
    route_sync_next = route_sync_reg;
    route_gnd_next  = route_gnd_reg;
    if (capture) begin
      auto_spin_next  = strap_auto_spin;
      par_en_next     = strap_parity;
      sdtr_en_next    = strap_sdtr;
      ua_inhibit_next = strap_unit_attn;
      fseek_next      = strap_fast_seek;
      s1_strap_next   = strap_scsi1;
      wp_strap_next   = strap_write_prot;
      id_next         = strap_unit_sel;
      route_sync_next = strap_sync_route;
      route_gnd_next  = strap_pin29_gnd;
    end
  end

  always_comb begin
    // Spin-up at the end of the power-on capture only; later bus resets keep the spindle state
    run_next = run_reg;
    if (state_reg == strap_decoder_pkg::ST_LOAD && !config_valid && auto_spin_reg == 1'b0 && strap_auto_spin) begin
      run_next = 1'b1;
    end else if (start_unit_cmd) begin
      run_next = 1'b1;
    end else if (stop_unit_cmd) begin
      run_next = 1'b0;
    end
    // One SDTR request each time a capture ends with the SDTR strap shorted
    sdtr_req_next = (state_reg == strap_decoder_pkg::ST_LOAD) && !bus_reset && sdtr_en_next;
    par_err_next  = par_en_reg && rx_parity_bad;
    // Uses the value being captured so a shorted strap also hides attention in the capture cycle
    ua_rep_next   = !ua_inhibit_next && unit_attn_pending;
    s1_mode_next  = s1_strap_reg || mode_page09_byte8[strap_decoder_pkg::SCSI1_MODE_BIT];
    wp_next       = wp_strap_reg || mode_hdr_write_prot;
    msync_next    = spindle_index;
    ssync_next    = slave_sync_in || (sync_spindle_mode && route_sync_reg && !route_gnd_reg
                                      && !spindle_master && pin29_in);
  end

  // Tracks whether the power-on capture has already been done
  logic pwr_done_reg, pwr_done_next;
  assign pwr_done_next = pwr_done_reg || (state_reg == strap_decoder_pkg::ST_HOLD);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg      <= strap_decoder_pkg::ST_LOAD;
      pwr_done_reg   <= strap_decoder_pkg::RST_FLAG;
      auto_spin_reg  <= strap_decoder_pkg::RST_FLAG;
      run_reg        <= strap_decoder_pkg::RST_FLAG;
      par_en_reg     <= strap_decoder_pkg::RST_FLAG;
      par_err_reg    <= strap_decoder_pkg::RST_FLAG;
      sdtr_en_reg    <= strap_decoder_pkg::RST_FLAG;
      sdtr_req_reg   <= strap_decoder_pkg::RST_FLAG;
      ua_inhibit_reg <= strap_decoder_pkg::RST_FLAG;
      ua_rep_reg     <= strap_decoder_pkg::RST_FLAG;
      fseek_reg      <= strap_decoder_pkg::RST_FLAG;
      s1_strap_reg   <= strap_decoder_pkg::RST_FLAG;
      s1_mode_reg    <= strap_decoder_pkg::RST_FLAG;
      wp_strap_reg   <= strap_decoder_pkg::RST_FLAG;
      wp_reg         <= strap_decoder_pkg::RST_FLAG;
      id_reg         <= strap_decoder_pkg::RST_ADDR;
      route_sync_reg <= strap_decoder_pkg::RST_FLAG;
      route_gnd_reg  <= strap_decoder_pkg::RST_FLAG;
      msync_reg      <= strap_decoder_pkg::RST_FLAG;
      ssync_reg      <= strap_decoder_pkg::RST_FLAG;
    end else begin
      state_reg      <= state_next;
      pwr_done_reg   <= pwr_done_next;
      auto_spin_reg  <= auto_spin_next;
      run_reg        <= run_next;
      par_en_reg     <= par_en_next;
      par_err_reg    <= par_err_next;
      sdtr_en_reg    <= sdtr_en_next;
      sdtr_req_reg   <= sdtr_req_next;
      ua_inhibit_reg <= ua_inhibit_next;
      ua_rep_reg     <= ua_rep_next;
      fseek_reg      <= fseek_next;
      s1_strap_reg   <= s1_strap_next;
      s1_mode_reg    <= s1_mode_next;
      wp_strap_reg   <= wp_strap_next;
      wp_reg         <= wp_next;
      id_reg         <= id_next;
      route_sync_reg <= route_sync_next;
      route_gnd_reg  <= route_gnd_next;
      msync_reg      <= msync_next;
      ssync_reg      <= ssync_next;
    end
  end

  assign config_valid     = pwr_done_reg;
  assign spindle_run      = run_reg;
  assign parity_check_en  = par_en_reg;
  assign parity_error     = par_err_reg;
  assign sdtr_request     = sdtr_req_reg;
  assign unit_attn_report = ua_rep_reg;
  assign fast_seek_en     = fseek_reg;
  assign scsi1_mode       = s1_mode_reg;
  assign write_protect    = wp_reg;
  assign scsi_id          = id_reg;
  assign master_sync_out  = msync_reg;
  assign slave_sync_seen  = ssync_reg;

  // Pin 29 routing acts only in sync spindle mode; illegal strap pairs leave the pin undriven
  assign route_illegal = sync_spindle_mode && (route_sync_reg == route_gnd_reg);
  assign pin29_oe      = sync_spindle_mode && (route_sync_reg != route_gnd_reg)
                         && (route_gnd_reg || spindle_master);
  assign pin29_out     = route_sync_reg && !route_gnd_reg && msync_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  id_hold_a: assert property (!capture && !$past(capture) |-> $stable(scsi_id))
    else $error("Address changed outside capture");
  id_load_a: assert property (bus_reset |=> scsi_id == $past(strap_unit_sel))
    else $error("Address not taken from unit select straps");
  parity_gate_a: assert property (parity_error |-> $past(parity_check_en) && $past(rx_parity_bad))
    else $error("Parity error flagged while checking disabled");
  sdtr_cond_a: assert property (sdtr_request |-> $past(state_reg == strap_decoder_pkg::ST_LOAD) && sdtr_en_reg)
    else $error("SDTR request without strap or capture");
  sdtr_after_a: assert property ($fell(bus_reset) && strap_sdtr |=> ##[0:1] sdtr_request)
    else $error("No SDTR request after bus reset");
  ua_supp_a: assert property (unit_attn_report |-> !ua_inhibit_reg)
    else $error("Unit attention reported while inhibited");
  fseek_load_a: assert property (bus_reset |=> fast_seek_en == $past(strap_fast_seek))
    else $error("Fast seek not following strap");
  scsi1_force_a: assert property (s1_strap_reg |=> scsi1_mode)
    else $error("SCSI-1 not forced by strap");
  wp_force_a: assert property (wp_strap_reg |=> write_protect)
    else $error("Write protect not forced by strap");
  pin29_off_a: assert property (!sync_spindle_mode |-> !pin29_oe)
    else $error("Pin 29 driven with sync spindle mode off");
  pin29_gnd_a: assert property (pin29_oe && route_gnd_reg |-> !pin29_out && !route_sync_reg)
    else $error("Pin 29 not grounded");
  msync_a: assert property (!$past(reset) |-> master_sync_out == $past(spindle_index))
    else $error("Master sync not following index");
  spin_auto_a: assert property ($rose(config_valid) && $past(strap_auto_spin, 2) |-> spindle_run)
    else $error("Auto spin-up missed");

  cov_bus_reset_c: cover property ($fell(bus_reset) ##[1:3] sdtr_request);
  cov_start_unit_c: cover property (!spindle_run ##1 start_unit_cmd ##1 spindle_run);
  cov_route_sync_c: cover property (pin29_oe && route_sync_reg);
  cov_illegal_c: cover property (route_illegal);

endmodule : drive_option_strap_decoder

// *** tb/strap_partner_model.sv ***
/*
  Far side of bus pin 29 for the strap decoder bench: another drive sharing the sync line.
  Assumes that drive sends its sync on the terminated line whenever this one lets go of it.
*/
module strap_partner_model (
  input  wire logic pin29_out,
  input  wire logic pin29_oe,
  input  wire logic ext_sync,
  output logic      pin29_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Wire level resolved from both parties: the drive wins while it drives
  assign pin29_in = pin29_oe ? pin29_out : ext_sync;
endmodule : strap_partner_model

// *** tb/drive_option_strap_decoder_tb.sv ***
/*
  Self-checking bench for the drive option strap decoder.
  Assumes a 100 MHz ref_clk, shorted straps read as 1, and the pin 29 partner model beside it.
*/
module drive_option_strap_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0, reset = 1'b1, bus_reset = 1'b0, strap_auto_spin = 1'b1, strap_parity = 1'b1;
  logic strap_sdtr = 1'b1, strap_unit_attn = 1'b0, strap_fast_seek = 1'b1, strap_scsi1 = 1'b0;
  logic strap_write_prot = 1'b0, strap_sync_route = 1'b0, strap_pin29_gnd = 1'b0, start_unit_cmd = 1'b0;
  logic stop_unit_cmd = 1'b0, rx_parity_bad = 1'b1, unit_attn_pending = 1'b1, mode_hdr_write_prot = 1'b0;
  logic sync_spindle_mode = 1'b0, spindle_master = 1'b0, spindle_index = 1'b0, slave_sync_in = 1'b0;
  logic ext_sync = 1'b0, pin29_in, config_valid, spindle_run, parity_check_en, parity_error, sdtr_request;
  logic unit_attn_report, fast_seek_en, scsi1_mode, write_protect, route_illegal, pin29_out, pin29_oe;
  logic master_sync_out, slave_sync_seen;
  logic [strap_decoder_pkg::ADDR_W-1:0]      strap_unit_sel = 3'h5;
  logic [strap_decoder_pkg::ADDR_W-1:0]      scsi_id;
  logic [strap_decoder_pkg::MODE_BYTE_W-1:0] mode_page09_byte8 = 8'h00;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  drive_option_strap_decoder i_drive_option_strap_decoder (.ref_clk, .reset, .bus_reset, .strap_auto_spin,
    .strap_parity, .strap_sdtr, .strap_unit_attn, .strap_fast_seek, .strap_scsi1, .strap_write_prot,
    .strap_unit_sel, .strap_sync_route, .strap_pin29_gnd, .start_unit_cmd, .stop_unit_cmd, .rx_parity_bad,
    .unit_attn_pending, .mode_page09_byte8, .mode_hdr_write_prot, .sync_spindle_mode, .spindle_master,
    .spindle_index, .slave_sync_in, .pin29_in, .config_valid, .spindle_run, .parity_check_en, .parity_error,
    .sdtr_request, .unit_attn_report, .fast_seek_en, .scsi1_mode, .write_protect, .scsi_id, .route_illegal,
    .pin29_out, .pin29_oe, .master_sync_out, .slave_sync_seen);
  strap_partner_model i_strap_partner_model (.pin29_out, .pin29_oe, .ext_sync, .pin29_in);

  always #5 ref_clk = ~ref_clk;

  // Run takes about 120 cycles; cut a hang well beyond that
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Mismatches %0d, checks %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic power_on();
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    step(1);
    chk(spindle_run, 1'b1, "auto spin-up");
    chk(config_valid, 1'b0, "valid too early");
    chk(sdtr_request, 1'b1, "sdtr after power-on");
    step(1);
    chk(sdtr_request, 1'b0, "sdtr single pulse");
    chk(config_valid, 1'b1, "valid after capture");
    chk(scsi_id, 3'h5, "power-on address");
    step(1);
    chk(sdtr_request, 1'b0, "sdtr pulse end");
    strap_unit_sel <= 3'h2;
    strap_parity <= 1'b0;
    step(4);
    chk(scsi_id, 3'h5, "address held");
    chk(parity_check_en, 1'b1, "parity held");
  endtask : power_on

  task automatic recapture(input logic [2:0] id, input logic f);
    int pulses;
    pulses = 0;
    @(posedge ref_clk);
    strap_unit_sel <= id;
    {strap_parity, strap_fast_seek, strap_unit_attn, strap_sdtr} <= {f, f, ~f, f};
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
    repeat (4) begin
      step(1);
      pulses += int'(sdtr_request);
    end
    chk(3'(pulses), {2'b00, f}, "sdtr pulses");
    chk(scsi_id, id, "bus address");
    chk(parity_error, f, "parity check");
    chk(unit_attn_report, f, "unit attention");
    chk(fast_seek_en, f, "fast seek");
    chk(spindle_run, 1'b1, "spindle kept");
  endtask : recapture

  task automatic event_gates();
    rx_parity_bad <= 1'b0;
    unit_attn_pending <= 1'b0;
    step(1);
    chk(parity_error, 1'b0, "no parity event");
    chk(unit_attn_report, 1'b0, "no attention pending");
    rx_parity_bad <= 1'b1;
    unit_attn_pending <= 1'b1;
    step(1);
    chk(parity_error, 1'b1, "parity event");
    chk(unit_attn_report, 1'b1, "attention pending");
  endtask : event_gates

  task automatic mode_checks();
    @(posedge ref_clk);
    mode_page09_byte8 <= 8'h10;
    mode_hdr_write_prot <= 1'b1;
    step(1);
    chk(scsi1_mode, 1'b1, "mode bit 4");
    chk(write_protect, 1'b1, "header protect");
    mode_page09_byte8 <= 8'hEF;
    mode_hdr_write_prot <= 1'b0;
    strap_scsi1 <= 1'b1;
    strap_write_prot <= 1'b1;
    step(1);
    chk(scsi1_mode, 1'b0, "other mode bits");
    chk(write_protect, 1'b0, "default unprotected");
    recapture(3'h7, 1'b1);
    chk(scsi1_mode, 1'b1, "forced scsi-1");
    chk(write_protect, 1'b1, "forced protect");
  endtask : mode_checks

  task automatic route_case(input logic r, input logic g);
    @(posedge ref_clk);
    strap_sync_route <= r;
    strap_pin29_gnd <= g;
    recapture(3'h7, 1'b1);
  endtask : route_case

  task automatic pin29_routes();
    route_case(1'b0, 1'b1);
    sync_spindle_mode <= 1'b1;
    spindle_master <= 1'b1;
    spindle_index <= 1'b1;
    step(1);
    chk({pin29_oe, pin29_out}, 3'h2, "pin 29 grounded");
    route_case(1'b1, 1'b0);
    chk(master_sync_out, 1'b1, "master sync out");
    chk({pin29_oe, pin29_out}, 3'h3, "sync on pin 29");
    spindle_master <= 1'b0;
    ext_sync <= 1'b1;
    step(1);
    chk({pin29_oe, slave_sync_seen}, 3'h1, "slave via pin 29");
    ext_sync <= 1'b0;
    step(1);
    chk(slave_sync_seen, 1'b0, "slave idle");
    slave_sync_in <= 1'b1;
    step(1);
    chk(slave_sync_seen, 1'b1, "slave sync input");
    route_case(1'b1, 1'b1);
    chk({route_illegal, pin29_oe}, 3'h2, "equal straps");
    route_case(1'b0, 1'b0);
    chk({route_illegal, pin29_oe}, 3'h2, "both open");
    sync_spindle_mode <= 1'b0;
    spindle_index <= 1'b0;
    step(1);
    chk(route_illegal, 1'b0, "sync mode off");
    chk(master_sync_out, 1'b0, "master sync low");
  endtask : pin29_routes

  task automatic spin_cmds();
    strap_auto_spin <= 1'b0;
    reset <= 1'b1;
    step(2);
    reset <= 1'b0;
    step(3);
    chk(spindle_run, 1'b0, "no auto spin-up");
    start_unit_cmd <= 1'b1;
    step(1);
    chk(spindle_run, 1'b1, "start unit");
    start_unit_cmd <= 1'b0;
    stop_unit_cmd <= 1'b1;
    step(1);
    chk(spindle_run, 1'b0, "stop unit");
    start_unit_cmd <= 1'b1;
    step(1);
    chk(spindle_run, 1'b1, "start over stop");
  endtask : spin_cmds

  initial begin
    power_on();
    for (int a = 0; a < 8; a++) recapture(3'(a), a[0]);
    event_gates();
    mode_checks();
    pin29_routes();
    spin_cmds();
    give_verdict();
  end
endmodule : drive_option_strap_decoder_tb
